/* File: hw/mppc_consts.vh */
// constants for the multi profile pll configuration block
`ifndef MPPC_CONSTS_VH
`define MPPC_CONSTS_VH

// ----------------------------------------------------------------
// serial port
// ----------------------------------------------------------------
`define MPPC_I2C_ADDR 7'h6E
`define MPPC_BYTE_BITS 4'h8

// ----------------------------------------------------------------
// register groups: offset = group * 4 + profile
// ----------------------------------------------------------------
`define MPPC_GRP_FB 6'h00
`define MPPC_GRP_OUT 6'h01
`define MPPC_GRP_CTL 6'h02
`define MPPC_GRP_STY 6'h03
`define MPPC_GRP_OE 6'h04

// ----------------------------------------------------------------
// field positions in the control and per-output bytes
// ----------------------------------------------------------------
`define MPPC_BYP_BIT 6
`define MPPC_PS_LSB 4
`define MPPC_P_LSB 2
`define MPPC_CP_LSB 0
`define MPPC_Q0_BIT 1
`define MPPC_Q1_BIT 2
`define MPPC_Q2_BIT 5
`define MPPC_Q3_BIT 6

// ----------------------------------------------------------------
// factory contents, same for every profile
// ----------------------------------------------------------------
`define MPPC_RST_FB 8'h19
`define MPPC_RST_OUT 7'h04
`define MPPC_RST_BYP 1'h0
`define MPPC_RST_PS 2'h2
`define MPPC_RST_P 2'h0
`define MPPC_RST_CP 2'h1
`define MPPC_RST_OE 4'hF
`define MPPC_RST_STY 4'hF

// ----------------------------------------------------------------
// decode values and legal code limits
// ----------------------------------------------------------------
`define MPPC_PRE_X1 2'h0
`define MPPC_PRE_HALF 2'h1
`define MPPC_PRE_X2 2'h2
`define MPPC_FB_MIN 8'h08
`define MPPC_FB_MAX 8'h7D
`define MPPC_OUT_MIN 7'h02
`define MPPC_OUT_FULL_MAX 7'h05

`endif

/* File: hw/mppc_decode.v */
// combinational decode of one profile's divider codes
`timescale 1ns/1ps
`include "mppc_consts.vh"
module mppc_decode (
	input wire [1:0] ref_divide_code,
	input wire [1:0] prescale_code,
	input wire [7:0] feedback_ratio_code,
	input wire [6:0] out_ratio_code,
	input wire ref_is_crystal,
	output reg [2:0] ref_ratio,
	output reg [1:0] prescale_mode,
	output wire [8:0] feedback_ratio,
	output reg [6:0] out_ratio,
	output wire code_fault
);

// ----------------------------------------------------------------
// input divider and prescaler
// ----------------------------------------------------------------
always @* begin
	case (ref_divide_code)
	2'h0: ref_ratio = 3'h1;
	2'h1: ref_ratio = 3'h2;
	2'h2: ref_ratio = 3'h4;
	default: ref_ratio = 3'h5;
	endcase
	if (ref_is_crystal) begin
		ref_ratio = 3'h1;
	end
	if (prescale_code[1]) begin
		prescale_mode = `MPPC_PRE_X2;
	end else if (prescale_code[0]) begin
		prescale_mode = `MPPC_PRE_HALF;
	end else begin
		prescale_mode = `MPPC_PRE_X1;
	end
end

// ----------------------------------------------------------------
// feedback and output dividers
// ----------------------------------------------------------------
// stored bits are ratio[8:1]
assign feedback_ratio = {feedback_ratio_code, 1'b0};

always @* begin
	if (out_ratio_code < `MPPC_OUT_MIN) begin
		// forbidden codes still give the smallest ratio
		out_ratio = `MPPC_OUT_MIN;
	end else if (out_ratio_code <= `MPPC_OUT_FULL_MAX) begin
		out_ratio = out_ratio_code;
	end else begin
		out_ratio = {out_ratio_code[6:1], 1'b0};
	end
end

// flag codes the host must avoid
assign code_fault = (feedback_ratio_code < `MPPC_FB_MIN) ||
	(feedback_ratio_code > `MPPC_FB_MAX) ||
	(out_ratio_code < `MPPC_OUT_MIN);

endmodule

/* File: hw/mppc_sync.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mppc_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input wire clk_sys,
	input wire rst,
	input wire [WIDTH-1:0] pin,
	output wire [WIDTH-1:0] level
);

// ----------------------------------------------------------------
// per-bit chain
// ----------------------------------------------------------------
genvar i;
generate
	for (i = 0; i < WIDTH; i = i + 1) begin : bit_sync
		reg s1;
		reg s2;
		reg s3;
		reg filt;
		// filt moves only when stages two and three agree
		always @(posedge clk_sys) begin
			if (rst) begin
				s1 <= INIT[i];
				s2 <= INIT[i];
				s3 <= INIT[i];
				filt <= INIT[i];
			end else begin
				s1 <= pin[i];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					filt <= s3;
				end
			end
		end
		assign level[i] = filt;
	end
endgenerate

endmodule

/* File: hw/mppc_top.v */
// four-profile pll configuration with two-wire serial register port
// Operation
// - input divider code 00,01,10,11 gives divide by 1,2,4,5, except that ref_is_crystal forces divide by 1.
// - prescaler code 00 is x1, 01 is x0.5, 1x is x2.
// - feedback field holds ratio bits 8:1; applied ratio is twice it.
// - output codes 2 to 5 give exactly 2 to 5; 000000X forbidden.
// - output codes from 000011X ignore lsb, giving even 6 to 126.
// - bandwidth code selects charge pump current for its ratio range.
// - bypass set sends prescaler output straight to output divider.
// - bypass clear feeds the pll; output divider divides oscillator.
// - per-output enable bit: 0 high impedance, 1 driven.
// - per-output style bit: 1 lvds, 0 lvpecl.
// - four copies of every field, loaded with factory contents.
// - selection pins choose the active profile at any time.
`timescale 1ns/1ps
`include "mppc_consts.vh"
module mppc_top (
	input wire clk_sys,
	input wire rst,
	input wire scl,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire [1:0] profile_select_pins,
	input wire ref_is_crystal,
	output reg [1:0] active_profile,
	output reg [2:0] ref_ratio,
	output reg [1:0] prescale_mode,
	output reg [8:0] feedback_ratio,
	output reg [6:0] out_ratio,
	output reg [1:0] loop_bandwidth_code,
	output reg loop_skip,
	output reg [3:0] output_drive_on,
	output reg [3:0] output_style_sel,
	output reg config_fault
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
wire scl_s;
wire sda_s;
wire [1:0] sel_s;
wire xtal_s;

// bus lines idle high, so they reset to one
mppc_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
	.clk_sys(clk_sys),
	.rst(rst),
	.pin({scl, sda_in}),
	.level({scl_s, sda_s})
);

mppc_sync #(.WIDTH(3), .INIT(3'h0)) u_pin_sync (
	.clk_sys(clk_sys),
	.rst(rst),
	.pin({ref_is_crystal, profile_select_pins}),
	.level({xtal_s, sel_s})
);

// ----------------------------------------------------------------
// bus edge and condition detection
// ----------------------------------------------------------------
reg scl_d;
reg sda_d;
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

// one-cycle history of the filtered lines
always @(posedge clk_sys) begin
	if (rst) begin
		scl_d <= 1'b1;
		sda_d <= 1'b1;
	end else begin
		scl_d <= scl_s;
		sda_d <= sda_s;
	end
end

// ----------------------------------------------------------------
// serial slave state machine
// ----------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_ACK = 3'h2;
localparam ST_WRB = 3'h3;
localparam ST_RDB = 3'h4;
localparam ST_RACK = 3'h5;

reg [2:0] state;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg [7:0] ptr;
reg rw;
reg want_ptr;
reg host_nack;
reg wr_en;
reg [7:0] wr_addr;
reg [7:0] wr_data;
wire [7:0] rd_byte;

// bytes move msb first; the line only changes while scl is low
always @(posedge clk_sys) begin
	if (rst) begin
		state <= ST_IDLE;
		bit_cnt <= 4'h0;
		shreg <= 8'h00;
		ptr <= 8'h00;
		rw <= 1'b0;
		want_ptr <= 1'b0;
		host_nack <= 1'b0;
		sda_oe <= 1'b0;
		sda_out <= 1'b0;
		wr_en <= 1'b0;
		wr_addr <= 8'h00;
		wr_data <= 8'h00;
	end else begin
		wr_en <= 1'b0;
		if (bus_start) begin
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (bus_stop) begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
		end else if (scl_rise) begin
			if (state == ST_ADDR || state == ST_WRB) begin
				shreg <= {shreg[6:0], sda_s};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (state == ST_RDB) begin
				bit_cnt <= bit_cnt + 4'h1;
			end else if (state == ST_RACK) begin
				host_nack <= sda_s;
			end
		end else if (scl_fall) begin
			case (state)
			ST_ADDR: begin
				if (bit_cnt == `MPPC_BYTE_BITS) begin
					if (shreg[7:1] == `MPPC_I2C_ADDR) begin
						sda_oe <= 1'b1;
						rw <= shreg[0];
						want_ptr <= ~shreg[0];
						state <= ST_ACK;
					end else begin
						state <= ST_IDLE;
					end
				end
			end
			ST_ACK: begin
				bit_cnt <= 4'h0;
				if (rw) begin
					shreg <= rd_byte;
					sda_oe <= ~rd_byte[7];
					ptr <= ptr + 8'h01;
					state <= ST_RDB;
				end else begin
					sda_oe <= 1'b0;
					state <= ST_WRB;
				end
			end
			ST_WRB: begin
				if (bit_cnt == `MPPC_BYTE_BITS) begin
					// first byte after the address is the pointer
					if (want_ptr) begin
						ptr <= shreg;
						want_ptr <= 1'b0;
					end else begin
						wr_en <= 1'b1;
						wr_addr <= ptr;
						wr_data <= shreg;
						ptr <= ptr + 8'h01;
					end
					sda_oe <= 1'b1;
					state <= ST_ACK;
				end
			end
			ST_RDB: begin
				if (bit_cnt == `MPPC_BYTE_BITS) begin
					sda_oe <= 1'b0;
					state <= ST_RACK;
				end else begin
					shreg <= {shreg[6:0], 1'b0};
					sda_oe <= ~shreg[6];
				end
			end
			ST_RACK: begin
				// a nack from the host ends the block read
				if (host_nack) begin
					state <= ST_IDLE;
				end else begin
					bit_cnt <= 4'h0;
					shreg <= rd_byte;
					sda_oe <= ~rd_byte[7];
					ptr <= ptr + 8'h01;
					state <= ST_RDB;
				end
			end
			default: begin
				sda_oe <= 1'b0;
			end
			endcase
		end
	end
end

// ----------------------------------------------------------------
// per-profile field storage
// ----------------------------------------------------------------
wire [31:0] fb_all;
wire [27:0] out_all;
wire [3:0] byp_all;
wire [7:0] ps_all;
wire [7:0] p_all;
wire [7:0] cp_all;
wire [15:0] oe_all;
wire [15:0] sty_all;
wire [5:0] wr_grp = wr_addr[7:2];

genvar g;
generate
	for (g = 0; g < 4; g = g + 1) begin : prof
		reg [7:0] fb;
		reg [6:0] outc;
		reg byp;
		reg [1:0] ps;
		reg [1:0] pd;
		reg [1:0] cp;
		reg [3:0] oe;
		reg [3:0] sty;
		always @(posedge clk_sys) begin
			if (rst) begin
				fb <= `MPPC_RST_FB;
				outc <= `MPPC_RST_OUT;
				byp <= `MPPC_RST_BYP;
				ps <= `MPPC_RST_PS;
				pd <= `MPPC_RST_P;
				cp <= `MPPC_RST_CP;
				oe <= `MPPC_RST_OE;
				sty <= `MPPC_RST_STY;
			end else if (wr_en && wr_addr[1:0] == g) begin
				case (wr_grp)
				`MPPC_GRP_FB: fb <= wr_data;
				`MPPC_GRP_OUT: outc <= wr_data[6:0];
				`MPPC_GRP_CTL: begin
					byp <= wr_data[`MPPC_BYP_BIT];
					ps <= wr_data[`MPPC_PS_LSB +: 2];
					pd <= wr_data[`MPPC_P_LSB +: 2];
					cp <= wr_data[`MPPC_CP_LSB +: 2];
				end
				`MPPC_GRP_STY: sty <= {wr_data[`MPPC_Q3_BIT],
					wr_data[`MPPC_Q2_BIT], wr_data[`MPPC_Q1_BIT],
					wr_data[`MPPC_Q0_BIT]};
				`MPPC_GRP_OE: oe <= {wr_data[`MPPC_Q3_BIT],
					wr_data[`MPPC_Q2_BIT], wr_data[`MPPC_Q1_BIT],
					wr_data[`MPPC_Q0_BIT]};
				default: ;
				endcase
			end
		end
		assign fb_all[g*8 +: 8] = fb;
		assign out_all[g*7 +: 7] = outc;
		assign byp_all[g] = byp;
		assign ps_all[g*2 +: 2] = ps;
		assign p_all[g*2 +: 2] = pd;
		assign cp_all[g*2 +: 2] = cp;
		assign oe_all[g*4 +: 4] = oe;
		assign sty_all[g*4 +: 4] = sty;
	end
endgenerate

// ----------------------------------------------------------------
// read-back mux; reserved and unused bits read zero
// ----------------------------------------------------------------
reg [7:0] rd_mux;
wire [1:0] rp = ptr[1:0];
wire [3:0] rd_oe = oe_all[rp*4 +: 4];
wire [3:0] rd_sty = sty_all[rp*4 +: 4];

always @* begin
	rd_mux = 8'h00;
	case (ptr[7:2])
	`MPPC_GRP_FB: rd_mux = fb_all[rp*8 +: 8];
	`MPPC_GRP_OUT: rd_mux = {1'b0, out_all[rp*7 +: 7]};
	`MPPC_GRP_CTL: rd_mux = {1'b0, byp_all[rp], ps_all[rp*2 +: 2],
		p_all[rp*2 +: 2], cp_all[rp*2 +: 2]};
	`MPPC_GRP_STY: rd_mux = {1'b0, rd_sty[3], rd_sty[2], 2'h0,
		rd_sty[1], rd_sty[0], 1'b0};
	`MPPC_GRP_OE: rd_mux = {1'b0, rd_oe[3], rd_oe[2], 2'h0,
		rd_oe[1], rd_oe[0], 1'b0};
	default: rd_mux = 8'h00;
	endcase
end
assign rd_byte = rd_mux;

// ----------------------------------------------------------------
// active profile decode
// ----------------------------------------------------------------
wire [2:0] dec_ref;
wire [1:0] dec_pre;
wire [8:0] dec_fb;
wire [6:0] dec_out;
wire dec_fault;

mppc_decode u_decode (
	.ref_divide_code(p_all[sel_s*2 +: 2]),
	.prescale_code(ps_all[sel_s*2 +: 2]),
	.feedback_ratio_code(fb_all[sel_s*8 +: 8]),
	.out_ratio_code(out_all[sel_s*7 +: 7]),
	.ref_is_crystal(xtal_s),
	.ref_ratio(dec_ref),
	.prescale_mode(dec_pre),
	.feedback_ratio(dec_fb),
	.out_ratio(dec_out),
	.code_fault(dec_fault)
);

always @(posedge clk_sys) begin
	if (rst) begin
		active_profile <= 2'h0;
		ref_ratio <= 3'h1;
		prescale_mode <= `MPPC_PRE_X1;
		feedback_ratio <= 9'h000;
		out_ratio <= `MPPC_OUT_MIN;
		loop_bandwidth_code <= 2'h0;
		loop_skip <= 1'b0;
		output_drive_on <= 4'h0;
		output_style_sel <= 4'h0;
		config_fault <= 1'b0;
	end else begin
		active_profile <= sel_s;
		ref_ratio <= dec_ref;
		prescale_mode <= dec_pre;
		feedback_ratio <= dec_fb;
		out_ratio <= dec_out;
		// code goes to charge pump as is
		loop_bandwidth_code <= cp_all[sel_s*2 +: 2];
		// zero means the pll is fed
		loop_skip <= byp_all[sel_s];
		output_drive_on <= oe_all[sel_s*4 +: 4];
		output_style_sel <= sty_all[sel_s*4 +: 4];
		config_fault <= dec_fault;
	end
end

endmodule

/* File: tb/mppc_checker.sv */
// port assertions for the pll configuration block
`timescale 1ns/1ps
module mppc_checker (
	input wire clk_sys,
	input wire rst,
	input wire scl,
	input wire sda_out,
	input wire sda_oe,
	input wire [1:0] profile_select_pins,
	input wire ref_is_crystal,
	input wire [1:0] active_profile,
	input wire [2:0] ref_ratio,
	input wire [1:0] prescale_mode,
	input wire [8:0] feedback_ratio,
	input wire [6:0] out_ratio,
	input wire [1:0] loop_bandwidth_code,
	input wire loop_skip,
	input wire [3:0] output_drive_on,
	input wire [3:0] output_style_sel,
	input wire config_fault
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// named steps: reset release, then a settled pin view
	// ------------------------------------------------------------
	sequence release_s;
		$past(rst) && !rst;
	endsequence
	sequence pins_still_s;
		$stable(profile_select_pins)[*8];
	endsequence
	sequence crystal_held_s;
		ref_is_crystal[*8];
	endsequence
	// outputs hold only legal decode values
	ref_set_a: assert property (
		ref_ratio inside {3'h1, 3'h2, 3'h4, 3'h5}) else $error("ref ratio");
	prescale_set_a: assert property (
		prescale_mode != 2'h3) else $error("prescale mode");
	fb_even_a: assert property (
		!feedback_ratio[0]) else $error("odd feedback");
	out_low_a: assert property (
		out_ratio >= 7'h02) else $error("output ratio low");
	out_even_a: assert property (
		out_ratio > 7'h05 |-> !out_ratio[0]) else $error("odd output");
	// reset values from the previous cycle are excluded
	fb_fault_a: assert property (
		!$past(rst) && (feedback_ratio < 9'h010 || feedback_ratio > 9'h0FA)
		|-> config_fault) else $error("fault missing");
	crystal_ref_a: assert property (
		crystal_held_s |-> ref_ratio == 3'h1) else $error("crystal ratio");
	profile_follow_a: assert property (
		pins_still_s |-> active_profile == profile_select_pins)
		else $error("profile lag");
	factory_load_a: assert property (
		release_s |=> feedback_ratio == 9'h032 && out_ratio == 7'h04
		&& prescale_mode == 2'h2 && ref_ratio == 3'h1 && !loop_skip
		&& loop_bandwidth_code == 2'h1 && output_drive_on == 4'hF
		&& output_style_sel == 4'hF) else $error("factory values");
	// open drain: the pad is only ever pulled low
	sda_drain_a: assert property (
		sda_oe |-> !sda_out) else $error("sda driven high");
	sda_hold_a: assert property (
		scl && $past(scl) |-> $stable(sda_oe)) else $error("sda moved");
endmodule
bind mppc_top mppc_checker i_chk (.clk_sys, .rst, .scl, .sda_out,
	.sda_oe, .profile_select_pins, .ref_is_crystal, .active_profile,
	.ref_ratio, .prescale_mode, .feedback_ratio, .out_ratio,
	.loop_bandwidth_code, .loop_skip, .output_drive_on,
	.output_style_sel, .config_fault);

/* File: tb/mppc_host.sv */
// host model for the two-wire configuration port
`timescale 1ns/1ps
`include "mppc_consts.vh"
module mppc_host (
	input wire clk_sys,
	input wire sda,
	output logic scl,
	output logic sda_low
);
	// idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// each line state lasts 11 clocks, above the 8 the port needs
	task automatic step(input logic c, input logic d);
		@(posedge clk_sys);
		scl <= c;
		sda_low <= d;
		repeat (10) @(posedge clk_sys);
	endtask
	// data moves only once the clock line is already low
	task automatic bit_io(input logic b, output logic r);
		step(1'b0, sda_low);
		step(1'b0, !b);
		step(1'b1, !b);
		r = sda;
	endtask
	task automatic byte_io(input logic [7:0] tx, input logic ak,
		output logic [7:0] rx, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ak, nak);
	endtask
	task automatic start();
		step(1'b0, sda_low);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	task automatic stop();
		step(1'b0, sda_low);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask
	task automatic wr(input logic [7:0] ad, ptr, dat, output logic ok);
		logic [7:0] rx;
		logic n0, n1, n2;
		start();
		byte_io(ad, 1'b1, rx, n0);
		byte_io(ptr, 1'b1, rx, n1);
		byte_io(dat, 1'b1, rx, n2);
		stop();
		ok = !(n0 | n1 | n2);
	endtask
	// single byte read, ended by a nack
	task automatic rd(input logic [7:0] ptr, output logic [7:0] dat,
		output logic ok);
		logic [7:0] rx;
		logic n0, n1, n2, n3;
		start();
		byte_io({`MPPC_I2C_ADDR, 1'b0}, 1'b1, rx, n0);
		byte_io(ptr, 1'b1, rx, n1);
		start();
		byte_io({`MPPC_I2C_ADDR, 1'b1}, 1'b1, rx, n2);
		byte_io(8'hFF, 1'b1, dat, n3);
		stop();
		ok = !(n0 | n1 | n2);
	endtask
	// two-byte block write; the pointer advances by itself
	task automatic wr2(input logic [7:0] ptr, d0, d1, output logic ok);
		logic [7:0] rx;
		logic n0, n1, n2, n3;
		start();
		byte_io({`MPPC_I2C_ADDR, 1'b0}, 1'b1, rx, n0);
		byte_io(ptr, 1'b1, rx, n1);
		byte_io(d0, 1'b1, rx, n2);
		byte_io(d1, 1'b1, rx, n3);
		stop();
		ok = !(n0 | n1 | n2 | n3);
	endtask
	// two-byte block read: host acks the first byte, nacks the second
	task automatic rd2(input logic [7:0] ptr, output logic [7:0] d0, d1,
		output logic ok);
		logic [7:0] rx;
		logic n0, n1, n2, n3, n4;
		start();
		byte_io({`MPPC_I2C_ADDR, 1'b0}, 1'b1, rx, n0);
		byte_io(ptr, 1'b1, rx, n1);
		start();
		byte_io({`MPPC_I2C_ADDR, 1'b1}, 1'b1, rx, n2);
		byte_io(8'hFF, 1'b0, d0, n3);
		byte_io(8'hFF, 1'b1, d1, n4);
		stop();
		ok = !(n0 | n1 | n2);
	endtask
endmodule

/* File: tb/mppc_tb.sv */
// self-checking bench for the pll configuration block
`timescale 1ns/1ps
`include "mppc_consts.vh"
module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [1:0] profile_select_pins = 2'h0;
	logic ref_is_crystal = 1'b0;
	logic ok;
	logic [7:0] rd_data;
	logic [7:0] rd_hi;
	wire scl, host_low, sda_out, sda_oe, loop_skip, config_fault;
	wire [1:0] active_profile, prescale_mode, loop_bandwidth_code;
	wire [2:0] ref_ratio;
	wire [8:0] feedback_ratio;
	wire [6:0] out_ratio;
	wire [3:0] output_drive_on, output_style_sel;
	// pulled-up line, low when either side pulls
	wire sda = !(host_low || (sda_oe && !sda_out));
	wire [32:0] outs = {feedback_ratio, out_ratio, loop_skip,
		prescale_mode, ref_ratio, loop_bandwidth_code, output_drive_on,
		output_style_sel, config_fault};
	int num_errors = 0;
	int n_checks = 0;
	logic [2:0] pr [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
	logic [1:0] pse [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	logic [7:0] fbc [4] = '{8'h08, 8'h18, 8'h32, 8'h60};
	logic [6:0] oc [11] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
		7'h06, 7'h07, 7'h08, 7'h7E, 7'h7F};
	logic [6:0] orx [11] = '{7'h02, 7'h02, 7'h02, 7'h03, 7'h04, 7'h05,
		7'h06, 7'h06, 7'h08, 7'h7E, 7'h7E};
	always #12.5 clk_sys = ~clk_sys;
	mppc_top i_dut (.clk_sys, .rst, .scl, .sda_in(sda), .sda_out,
		.sda_oe, .profile_select_pins, .ref_is_crystal, .active_profile,
		.ref_ratio, .prescale_mode, .feedback_ratio, .out_ratio,
		.loop_bandwidth_code, .loop_skip, .output_drive_on,
		.output_style_sel, .config_fault);
	mppc_host i_host (.clk_sys, .sda, .scl, .sda_low(host_low));
	task automatic give_verdict();
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [39:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] ptr, dat);
		i_host.wr({`MPPC_I2C_ADDR, 1'b0}, ptr, dat, ok);
		check("write ack", ok, 1'b1);
	endtask
	task automatic reg_rd(input logic [7:0] ptr, exp);
		i_host.rd(ptr, rd_data, ok);
		check("read ack", ok, 1'b1);
		check("read data", rd_data, exp);
	endtask
	// bounded wait for the synchronised selection to land
	task automatic set_pins(input logic [1:0] p);
		int k;
		@(posedge clk_sys);
		profile_select_pins <= p;
		for (k = 0; k < 20 && active_profile !== p; k++) begin
			@(posedge clk_sys);
		end
		if (k == 20) begin
			num_errors++;
			give_verdict();
		end
		repeat (2) @(posedge clk_sys);
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check("factory", outs, {9'h032, 7'h04, 1'b0, 2'h2, 3'h1, 2'h1,
			4'hF, 4'hF, 1'b0});
		reg_rd(8'h08, 8'h21);
		reg_rd(8'h10, 8'h66);
		reg_rd(8'h14, 8'h00);
		i_host.wr(8'hDE, 8'h01, 8'h00, ok);
		check("foreign address", ok, 1'b0);
		// profile 1: min ratio with its fitting bandwidth code
		reg_wr(8'h01, 8'h08);
		reg_wr(8'h05, 8'h03);
		reg_wr(8'h09, 8'h5C);
		reg_wr(8'h0D, 8'h02);
		reg_wr(8'h11, 8'h40);
		set_pins(2'h1);
		check("profile 1", outs, {9'h010, 7'h03, 1'b1, 2'h1, 3'h5, 2'h0,
			4'h8, 4'h1, 1'b0});
		reg_rd(8'h00, 8'h19);
		reg_rd(8'h0D, 8'h02);
		reg_rd(8'h11, 8'h40);
		// offsets past the map are acked, ignored and read zero
		reg_wr(8'h14, 8'hFF);
		reg_rd(8'h14, 8'h00);
		@(posedge clk_sys);
		ref_is_crystal <= 1'b1;
		repeat (10) @(posedge clk_sys);
		check("crystal ratio", ref_ratio, 3'h1);
		ref_is_crystal <= 1'b0;
		// each ratio paired with a bandwidth code covering it
		for (int i = 0; i < 4; i++) begin
			reg_wr(8'h01, fbc[i]);
			reg_wr(8'h09, {2'h0, i[1:0], i[1:0], i[1:0]});
			check("divider decode", {ref_ratio, prescale_mode,
				loop_bandwidth_code, loop_skip, feedback_ratio},
				{pr[i], pse[i], i[1:0], 1'b0, fbc[i], 1'b0});
		end
		for (int i = 0; i < 11; i++) begin
			reg_wr(8'h05, {1'b0, oc[i]});
			check("output decode", {config_fault, out_ratio},
				{i < 2, orx[i]});
		end
		// deliberately forbidden feedback code
		reg_wr(8'h01, 8'h07);
		check("low fb fault", {config_fault, feedback_ratio},
			{1'b1, 9'h00E});
		reg_wr(8'h01, 8'h7D);
		check("max fb", {config_fault, feedback_ratio},
			{1'b0, 9'h0FA});
		// auto-increment block access to profiles 2 and 3
		i_host.wr2(8'h02, 8'h20, 8'h7C, ok);
		check("block wr ack", ok, 1'b1);
		i_host.wr2(8'h0A, 8'h21, 8'h23, ok);
		check("block wr ack", ok, 1'b1);
		i_host.rd2(8'h02, rd_data, rd_hi, ok);
		check("block rd ack", ok, 1'b1);
		check("block rd 2", rd_data, 8'h20);
		check("block rd 3", rd_hi, 8'h7C);
		set_pins(2'h2);
		check("profile 2", outs, {9'h040, 7'h04, 1'b0, 2'h2, 3'h1,
			2'h1, 4'hF, 4'hF, 1'b0});
		set_pins(2'h3);
		check("profile 3", outs, {9'h0F8, 7'h04, 1'b0, 2'h2, 3'h1,
			2'h3, 4'hF, 4'hF, 1'b0});
		set_pins(2'h0);
		check("profile 0 fb", feedback_ratio, 9'h032);
		rst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reg_rd(8'h01, 8'h19);
		give_verdict();
	end
endmodule
